/* File: ctr_dir_cfg.svh */
// Notes on behaviour
// - Counters a0-a6: writable flag, set means down.
// - Counters c0-c7: read/write flag, set means down.
// - Counter b0 has optional writable down-select flag.
// - Monitors b0, b1 read direction, writes ignored.
// - Monitors b2, d2 read set while decrementing.
// - Inhibit flags d0, d1 block counter reset.
`ifndef CTR_DIR_CFG_SVH
`define CTR_DIR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_DIR_SEL_A 8'h00
`define OFS_DIR_SEL_B 8'h04
`define OFS_DIR_MON 8'h08
`define OFS_DIR_SEL_C 8'h0c
`define OFS_RST_INH 8'h10

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define W_SEL_A 7
`define W_SEL_B 1
`define W_SEL_C 8
`define W_INH 2
`define W_MON 4
`define POS_MON_B0 0
`define POS_MON_B1 1
`define POS_MON_B2 2
`define POS_MON_D2 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SEL_A 7'h00
`define RST_SEL_B 1'h0
`define RST_SEL_C 8'h00
`define RST_INH 2'h0
`define RST_MON 4'h0

`endif

/* File: ctr_dir_pkg.sv */
package ctr_dir_pkg;

    // Data word of the register bus.
    typedef logic [31:0] word_t;

    // Decoded register selection.
    typedef enum logic [2:0] {
        SEL_DIR_A = 3'b000,
        SEL_DIR_B = 3'b001,
        SEL_MON = 3'b010,
        SEL_DIR_C = 3'b011,
        SEL_INH = 3'b100,
        SEL_NONE = 3'b111
    } reg_sel_t;

endpackage

/* File: flag_wr_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Write port and stored value of one bank of flags.
interface flag_wr_if #(parameter int W = 1) ();
    logic wen;
    logic [W-1:0] wdata;
    logic [W-1:0] q;
    modport ctl (output wen, output wdata, input q);
    modport bank (input wen, input wdata, output q);
endinterface

`default_nettype wire

/* File: flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module flag_bank #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    flag_wr_if.bank port
);

    // ----------------------------------------------------------------
    // Flag storage
    // ----------------------------------------------------------------

    // Plain flops: the value is lost at reset and nothing but a bus
    // write changes it, so run and stop changes leave it alone.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            port.q <= RESET_VAL;
        else if (ce && port.wen)
            port.q <= port.wdata;
    end

endmodule

`default_nettype wire

/* File: ctr_dir_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ctr_dir_cfg.svh"

module ctr_dir_flags #(
    parameter bit HAS_B0_SEL = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [2:0] dir_live_b,
    input wire logic dir_live_d2,
    input wire logic [1:0] ctr_rst_pin_d,
    output logic [`W_SEL_A-1:0] dir_down_a,
    output logic dir_down_b0,
    output logic [`W_SEL_C-1:0] dir_down_c,
    output logic [1:0] ctr_rst_d
);

    // ----------------------------------------------------------------
    // Flag banks
    // ----------------------------------------------------------------

    flag_wr_if #(.W(`W_SEL_A)) sel_a ();
    flag_wr_if #(.W(`W_SEL_B)) sel_b ();
    flag_wr_if #(.W(`W_SEL_C)) sel_c ();
    flag_wr_if #(.W(`W_INH)) inh ();

    flag_bank #(.W(`W_SEL_A), .RESET_VAL(`RST_SEL_A)) u_sel_a (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .port(sel_a.bank)
    );
    flag_bank #(.W(`W_SEL_B), .RESET_VAL(`RST_SEL_B)) u_sel_b (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .port(sel_b.bank)
    );
    flag_bank #(.W(`W_SEL_C), .RESET_VAL(`RST_SEL_C)) u_sel_c (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .port(sel_c.bank)
    );
    flag_bank #(.W(`W_INH), .RESET_VAL(`RST_INH)) u_inh (
        .clk_sys(clk_sys), .reset(reset), .ce(ce), .port(inh.bank)
    );

    // ----------------------------------------------------------------
    // Bus address phase
    // ----------------------------------------------------------------

    logic wr_pend_q;
    ctr_dir_pkg::reg_sel_t wr_sel_q;
    ctr_dir_pkg::reg_sel_t addr_sel;
    logic addr_take;
    logic [`W_MON-1:0] mon_q;

    // Only the five listed aligned offsets in the low 256 bytes hit a register; reads may be any size, writes only whole words.
    always_comb
    begin
        addr_sel = ctr_dir_pkg::SEL_NONE;
        if (haddr[31:8] == 24'h000000 && haddr[1:0] == 2'h0)
        begin
            case (haddr[7:0])
                `OFS_DIR_SEL_A: addr_sel = ctr_dir_pkg::SEL_DIR_A;
                `OFS_DIR_SEL_B: addr_sel = ctr_dir_pkg::SEL_DIR_B;
                `OFS_DIR_MON: addr_sel = ctr_dir_pkg::SEL_MON;
                `OFS_DIR_SEL_C: addr_sel = ctr_dir_pkg::SEL_DIR_C;
                `OFS_RST_INH: addr_sel = ctr_dir_pkg::SEL_INH;
                default: addr_sel = ctr_dir_pkg::SEL_NONE;
            endcase
        end
    end

    assign addr_take = hsel && hready && htrans[1];

    // The slave never stalls, so ready stays high and the answer OKAY.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // A write is remembered until its data phase brings hwdata.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_pend_q <= 1'b0;
            wr_sel_q <= ctr_dir_pkg::SEL_NONE;
        end
        else if (ce && hready)
        begin
            wr_pend_q <= addr_take && hwrite && (hsize == 3'h2);
            wr_sel_q <= addr_sel;
        end
    end

    // ----------------------------------------------------------------
    // Data phase writes
    // ----------------------------------------------------------------

    // The monitor register has no write strobe, so writes to it vanish.
    always_comb
    begin
        sel_a.wen = wr_pend_q && (wr_sel_q == ctr_dir_pkg::SEL_DIR_A);
        sel_a.wdata = hwdata[`W_SEL_A-1:0];
        sel_b.wen = HAS_B0_SEL && wr_pend_q
            && (wr_sel_q == ctr_dir_pkg::SEL_DIR_B);
        sel_b.wdata = hwdata[`W_SEL_B-1:0];
        sel_c.wen = wr_pend_q && (wr_sel_q == ctr_dir_pkg::SEL_DIR_C);
        sel_c.wdata = hwdata[`W_SEL_C-1:0];
        inh.wen = wr_pend_q && (wr_sel_q == ctr_dir_pkg::SEL_INH);
        inh.wdata = hwdata[`W_INH-1:0];
    end

    // ----------------------------------------------------------------
    // Direction monitors
    // ----------------------------------------------------------------

    // The live directions come from counter logic on this clock.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mon_q <= `RST_MON;
        else if (ce)
        begin
            mon_q[`POS_MON_B0] <= dir_live_b[0];
            mon_q[`POS_MON_B1] <= dir_live_b[1];
            mon_q[`POS_MON_B2] <= dir_live_b[2];
            mon_q[`POS_MON_D2] <= dir_live_d2;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Read data is taken at the address edge so it comes from a flop;
    // the cost is that a monitor bit is two cycles old when read.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            hrdata <= 32'h00000000;
        else if (ce && hready)
        begin
            hrdata <= 32'h00000000;
            if (addr_take && !hwrite)
            begin
                case (addr_sel)
                    ctr_dir_pkg::SEL_DIR_A: hrdata[`W_SEL_A-1:0] <= sel_a.q;
                    ctr_dir_pkg::SEL_DIR_B: hrdata[`W_SEL_B-1:0] <= sel_b.q;
                    ctr_dir_pkg::SEL_MON: hrdata[`W_MON-1:0] <= mon_q;
                    ctr_dir_pkg::SEL_DIR_C: hrdata[`W_SEL_C-1:0] <= sel_c.q;
                    ctr_dir_pkg::SEL_INH: hrdata[`W_INH-1:0] <= inh.q;
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Counter controls
    // ----------------------------------------------------------------

    logic [1:0] rst_meta_q;
    logic [1:0] rst_sync_q;

    // The reset pins are asynchronous and pass two flops first.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rst_meta_q <= 2'h0;
            rst_sync_q <= 2'h0;
        end
        else if (ce)
        begin
            rst_meta_q <= ctr_rst_pin_d;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Direction selects and the gated counter resets, all from flops.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            dir_down_a <= `RST_SEL_A;
            dir_down_b0 <= `RST_SEL_B;
            dir_down_c <= `RST_SEL_C;
            ctr_rst_d <= 2'h0;
        end
        else if (ce)
        begin
            dir_down_a <= sel_a.q;
            dir_down_b0 <= HAS_B0_SEL ? sel_b.q[0] : 1'b0;
            dir_down_c <= sel_c.q;
            ctr_rst_d <= rst_sync_q & ~inh.q;
        end
    end

endmodule

`default_nettype wire

/* File: ctr_dir_flags_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker for the direction flags
// ----------------------------------------
module ctr_dir_flags_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [2:0] dir_live_b,
    input wire logic dir_live_d2,
    input wire logic [1:0] ctr_rst_pin_d,
    input wire logic [6:0] dir_down_a,
    input wire logic dir_down_b0,
    input wire logic [7:0] dir_down_c,
    input wire logic [1:0] ctr_rst_d
);
    logic take, wr_w, wr_a, wr_b, wr_c, rd_m;

    // Taken transfers; only whole-word writes may land in a flag.
    assign take = ce && hsel && hready && htrans[1];
    assign wr_w = take && hwrite && hsize == 3'b010;
    assign wr_a = wr_w && haddr == 32'h0;
    assign wr_b = wr_w && haddr == 32'h4;
    assign wr_c = wr_w && haddr == 32'hc;
    assign rd_m = take && !hwrite && haddr == 32'h8;

    logic wr_i_q;
    logic [1:0] inh_m_q;

    // Shadow of the inhibit flags built from the bus alone, so the gate
    // can be checked without peeking inside the design.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_i_q <= 1'b0;
            inh_m_q <= 2'b00;
        end
        else if (ce)
        begin
            wr_i_q <= wr_w && haddr == 32'h10;
            if (wr_i_q)
                inh_m_q <= hwdata[1:0];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_sel_a_write: assert property (
        $past(wr_a, 3) |-> dir_down_a == $past(hwdata[6:0], 2))
        else $error("dir_down_a wrong after write");
    a_sel_a_hold: assert property (
        !$stable(dir_down_a) |-> $past(wr_a, 3))
        else $error("dir_down_a changed without write");
    a_sel_b_write: assert property (
        $past(wr_b, 3) |-> dir_down_b0 == $past(hwdata[0], 2))
        else $error("dir_down_b0 wrong after write");
    a_sel_c_write: assert property (
        $past(wr_c, 3) |-> dir_down_c == $past(hwdata[7:0], 2))
        else $error("dir_down_c wrong after write");
    a_mon_b_read: assert property (
        rd_m |=> hrdata[1:0] == $past(dir_live_b[1:0], 2))
        else $error("monitor b0 b1 read wrong");
    a_mon_d_read: assert property (
        rd_m |=> hrdata[3:2] == {$past(dir_live_d2, 2), $past(dir_live_b[2], 2)})
        else $error("monitor b2 d2 read wrong");
    a_rst_gate_pin: assert property (
        (ctr_rst_d & ~$past(ctr_rst_pin_d, 3)) == 2'b00)
        else $error("counter reset without request");
    a_rst_inhibit_gate: assert property (
        (ctr_rst_d & $past(inh_m_q)) == 2'b00)
        else $error("counter reset passed while inhibited");
    a_reset_clears: assert property (
        $fell(reset) |-> {dir_down_a, dir_down_b0, dir_down_c, ctr_rst_d} == 18'h0)
        else $error("flags not cleared by reset");
endmodule

bind ctr_dir_flags ctr_dir_flags_monitor i_mon (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .dir_live_b(dir_live_b),
    .dir_live_d2(dir_live_d2), .ctr_rst_pin_d(ctr_rst_pin_d), .dir_down_a(dir_down_a),
    .dir_down_b0(dir_down_b0), .dir_down_c(dir_down_c), .ctr_rst_d(ctr_rst_d));

`default_nettype wire

/* File: counter_direction_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module counter_direction_flags_tb_top;
    logic clk_sys, reset, ce, hsel, hwrite, hready, hreadyout, hresp, dir_down_b0, dir_live_d2;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, ctr_rst_pin_d, ctr_rst_d;
    logic [2:0] hsize, dir_live_b;
    logic [6:0] dir_down_a;
    logic [7:0] dir_down_c;
    int n_mismatch = 0;
    int n_compared = 0;

    // A single slave, so its ready is the bus ready.
    assign hready = hreadyout;

    ctr_dir_flags i_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dir_live_b(dir_live_b), .dir_live_d2(dir_live_d2), .ctr_rst_pin_d(ctr_rst_pin_d),
        .dir_down_a(dir_down_a), .dir_down_b0(dir_down_b0), .dir_down_c(dir_down_c),
        .ctr_rst_d(ctr_rst_d));

    // Clock at 50 MHz.
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Compare one value and count it.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One word transfer; read data is taken at the edge that ends the data phase.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk_sys); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (!hready);
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wrap_up;
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // The sequence needs about 80 cycles; this bound cuts a stalled bus short.
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {hsel, hwrite, haddr, htrans, hwdata, dir_live_b, dir_live_d2, ctr_rst_pin_d} = '0;
        reset = 1'b1;
        ce = 1'b1;
        hsize = 3'b010;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, 32'(4 * i), 32'h0);
            check("reset value", 32'h0, rd);
        end
        xfer(1'b1, 32'h0, 32'hffff_ffaa);
        xfer(1'b1, 32'hc, 32'h0000_01a5);
        xfer(1'b1, 32'h4, 32'h0000_0003);
        xfer(1'b0, 32'h0, 32'h0);
        check("sel_a", 32'h2a, rd);
        xfer(1'b0, 32'hc, 32'h0);
        check("sel_c", 32'ha5, rd);
        xfer(1'b0, 32'h4, 32'h0);
        check("sel_b", 32'h1, rd);
        check("dir_down", 32'ha5aa, {16'h0, dir_down_c, dir_down_b0, dir_down_a});
        dir_live_b <= 3'b101;
        dir_live_d2 <= 1'b1;
        xfer(1'b1, 32'h8, 32'h2);
        xfer(1'b0, 32'h8, 32'h0);
        check("monitor", 32'hd, rd);
        dir_live_b <= 3'b010;
        dir_live_d2 <= 1'b0;
        xfer(1'b0, 32'h8, 32'h0);
        check("monitor", 32'h2, rd);
        xfer(1'b1, 32'h10, 32'h1);
        ctr_rst_pin_d <= 2'b11;
        repeat (5) @(posedge clk_sys);
        check("ctr_rst_d", 32'h2, {30'h0, ctr_rst_d});
        xfer(1'b1, 32'h10, 32'h0);
        repeat (3) @(posedge clk_sys);
        check("ctr_rst_d", 32'h3, {30'h0, ctr_rst_d});
        ctr_rst_pin_d <= 2'b00;
        xfer(1'b1, 32'h20, 32'hff);
        xfer(1'b0, 32'h20, 32'h0);
        check("unmapped", 32'h0, rd);
        // A byte-sized write must be refused and leave the flags alone.
        hsize <= 3'b000;
        xfer(1'b1, 32'h0, 32'h0);
        hsize <= 3'b010;
        xfer(1'b0, 32'h0, 32'h0);
        check("byte write", 32'h2a, rd);
        // Frozen clock enable stands in for a stop; a reset must then clear the direction selects.
        ce <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ce <= 1'b1;
        check("held", 32'ha5aa, {16'h0, dir_down_c, dir_down_b0, dir_down_a});
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        check("cleared", 32'h0, {16'h0, dir_down_c, dir_down_b0, dir_down_a});
        wrap_up();
    end
endmodule

`default_nettype wire
